// ### mpg_core_model.sv
// Behavioural CPU core model that issues accesses, vector calls and firmware pulses.
`timescale 1ns/100ps
module mpg_core_model (
	input wire logic CLK, // Core clock.
	output mpg_pkg::mpg_event_req_type EVENT, // Event request to the guard.
	output mpg_pkg::mpg_access_type CPU_ACC, // CPU access to the guard.
	output logic MMU_OK, // MMU right for the access.
	output logic BOOT_DONE, // Boot firmware finished.
	output logic TEST_DISABLE // Test firmware disables test mode.
);
	import mpg_pkg::*;
	// Idle values at time zero; every request changes at the falling edge only.
	initial begin
		EVENT = '0;
		CPU_ACC = '0;
		MMU_OK = 1'b0;
		BOOT_DONE = 1'b0;
		TEST_DISABLE = 1'b0;
	end
	// An idle bus shows the inverse of its last address, so a stale address never looks live.
	task automatic put_acc(input mpg_access_type a, input logic mmu);
		@(negedge CLK);
		if (!a.valid) a.addr = ~CPU_ACC.addr;
		CPU_ACC = a;
		MMU_OK = mmu;
	endtask
	// Software changes mode by an interrupt, vector call or return, each one cycle long.
	task automatic put_ev(input mpg_event_req_type e);
		@(negedge CLK);
		EVENT = e;
		@(negedge CLK);
		EVENT = '0;
	endtask
	// One-cycle firmware pulse: 0 ends boot setup, 1 disables test mode.
	task automatic pulse(input logic sel);
		@(negedge CLK);
		BOOT_DONE = !sel;
		TEST_DISABLE = sel;
		@(negedge CLK);
		BOOT_DONE = 1'b0;
		TEST_DISABLE = 1'b0;
	endtask
endmodule

// ### mpg_guard.sv
// CPU mode tracker and memory partition guard for the secure controller.
// Notes on behaviour
// - Five modes; three factory submodes under super-system.
// - Every reset starts in Boot mode.
// - Interrupt jumps to ROM vector, sets System/User; ignored in Boot and Test.
// - 8 config vectors, 32 system-call vectors.
// - ROM splits into application and factory parts.
// - EEPROM reserves manufacturer bytes plus contactless-OS part.
// - RAM privileged part is 0 or 128 bytes.
// - Test mode reaches every partition.
// - Boot and contactless OS use privileged parts only.
// - System and User use customer parts only.
// - System mode reaches all special function registers.
// - User mode limited to open registers plus MMU.
// - Coprocessor reaches only its own RAM part and customer EEPROM.
// - Coprocessor skips MMU but keeps partition boundary.
// - Test mode can be disabled permanently.
// - Start-up leads to Test, or System once disabled.
`timescale 1ns/100ps
module mpg_guard #(
	parameter int unsigned NUM_CONFIG_VECTOR = mpg_pkg::MPG_NUM_CONFIG_VECTOR,
	parameter int unsigned NUM_SYSTEM_CALL_VECTOR = mpg_pkg::MPG_NUM_SYSTEM_CALL_VECTOR
) (
	input wire logic CLK, // Core clock.
	input wire logic SYS_RST, // Synchronous reset, active high.
	input wire mpg_pkg::mpg_config_type CFG, // Partition and contactless configuration.
	input wire logic TEST_FUSE_OFF, // Fuse state: test mode already disabled.
	input wire logic TEST_DISABLE, // Pulse from test firmware to blow the fuse.
	input wire logic BOOT_DONE, // Pulse from boot firmware when setup is finished.
	input wire mpg_pkg::mpg_event_req_type EVENT, // Interrupt, vector call or return.
	input wire mpg_pkg::mpg_access_type CPU_ACC, // CPU fetch or data access.
	input wire logic MMU_OK, // MMU grants the current User access.
	input wire mpg_pkg::mpg_access_type COP_ACC, // Coprocessor RAM or EEPROM access.
	output logic CPU_GRANT, // CPU access may proceed.
	output logic COP_GRANT, // Coprocessor access may proceed.
	output mpg_pkg::mpg_mode_type MODE, // Current CPU mode.
	output logic SUPER, // Mode is a super-system submode.
	output mpg_pkg::mpg_jump_type JUMP, // Vector jump for the core.
	output logic FAULT, // One-cycle pulse on a blocked CPU access.
	output logic FUSE_BURN // One-cycle pulse that blows the test fuse.
);
	import mpg_pkg::*;

	// Vector indices must fit the index field of an event.
	// The check sits in a generate branch so that a bad instance is refused at elaboration.
	// A run-time check would let a wrongly sized guard start up and decode vectors.
	if (NUM_CONFIG_VECTOR < 1 || NUM_CONFIG_VECTOR > (1 << MPG_VIDX_W) || NUM_SYSTEM_CALL_VECTOR < 1 || NUM_SYSTEM_CALL_VECTOR > (1 << MPG_VIDX_W)) begin : g_bad_vec
		$error("mpg_guard: vector counts do not fit the index field");
	end

	mpg_mode_type mode;
	mpg_mode_type next_mode;
	mpg_mode_type saved_mode;
	mpg_mode_type next_saved_mode;
	logic locked;
	logic next_locked;
	mpg_jump_type next_jump;
	logic next_fault;
	logic next_burn;
	logic test_off;
	logic cpu_range;
	logic cpu_priv;
	logic cpu_cop;
	logic cop_range;
	logic cop_priv;
	logic cop_own;
	logic cpu_ok;
	logic cop_ok;
	logic sfr_acc;
	logic violation;
	logic ev_config_vector_ok;
	logic ev_system_call_vector_ok;
	logic ev_customer;

	// Vector address from a base and an index.
	function automatic logic [MPG_ADDR_W-1:0] vec_addr(input logic [MPG_ADDR_W-1:0] base,
		input logic [MPG_VIDX_W-1:0] idx);
		vec_addr = base + (MPG_ADDR_W'(idx) << MPG_VEC_SHIFT);
	endfunction

	// Both requesters share one classifier design, so the boundaries cannot drift apart.
	mpg_part_check u_cpu_check (
		.acc(CPU_ACC),
		.cfg(CFG),
		.in_range(cpu_range),
		.priv(cpu_priv),
		.cop_ram(cpu_cop)
	);

	mpg_part_check u_cop_check (
		.acc(COP_ACC),
		.cfg(CFG),
		.in_range(cop_range),
		.priv(cop_priv),
		.cop_ram(cop_own)
	);

	// CPU access rights per mode; RAM general and coprocessor parts are both open to the CPU.
	always_comb begin
		sfr_acc = CPU_ACC.space == MPG_SP_SFR;
		cpu_ok = 1'b0;
		case (mode)
			MPG_TEST: begin
				cpu_ok = cpu_range;
			end
			MPG_BOOT, MPG_CLOS: begin
				cpu_ok = cpu_range && (sfr_acc || cpu_priv);
			end
			MPG_SYSTEM: begin
				cpu_ok = cpu_range && (sfr_acc || !cpu_priv);
			end
			MPG_USER: begin
				if (sfr_acc) begin
					cpu_ok = cpu_range && (CPU_ACC.addr < MPG_SFR_USER_LIMIT || MMU_OK);
				end else begin
					cpu_ok = cpu_range && !cpu_priv && MMU_OK;
				end
			end
			default: begin
				cpu_ok = 1'b0;
			end
		endcase
		violation = CPU_ACC.valid && !cpu_ok;
		CPU_GRANT = CPU_ACC.valid && cpu_ok;
	end

	// Coprocessor needs no MMU right, but stays in its RAM part and customer partitions.
	always_comb begin
		case (COP_ACC.space)
			MPG_SP_RAM: cop_ok = cop_range && cop_own && !cop_priv;
			MPG_SP_EE: cop_ok = cop_range && !cop_priv;
			default: cop_ok = 1'b0;
		endcase
		COP_GRANT = COP_ACC.valid && cop_ok;
	end

	// Event qualification: customer software may only call vectors from its own modes.
	always_comb begin
		test_off = locked || TEST_FUSE_OFF;
		ev_customer = mode == MPG_SYSTEM || mode == MPG_USER;
		ev_config_vector_ok = ev_customer && CFG.clos_enable && 32'(EVENT.index) < NUM_CONFIG_VECTOR;
		ev_system_call_vector_ok = ev_customer && 32'(EVENT.index) < NUM_SYSTEM_CALL_VECTOR;
	end

	// Next mode, saved mode, fuse lock and output pulses.
	always_comb begin
		next_mode = mode;
		next_saved_mode = saved_mode;
		next_locked = locked || TEST_FUSE_OFF;
		next_jump = '0;
		next_fault = 1'b0;
		next_burn = 1'b0;
		if (violation && mode != MPG_TEST) begin
			next_mode = MPG_SYSTEM;
			next_saved_mode = mode;
			next_jump.valid = 1'b1;
			next_jump.addr = MPG_VEC_FAULT;
			next_fault = 1'b1;
		end else if (violation) begin
			next_fault = 1'b1; // Test mode only trips on an address outside the memory of the addressed space.
		end else begin
			case (mode)
				MPG_BOOT: begin
					// Boot firmware offers no interaction, so events are not taken here.
					if (BOOT_DONE) begin
						next_mode = test_off ? MPG_SYSTEM : MPG_TEST;
					end
				end
				MPG_TEST: begin
					if (TEST_DISABLE || test_off) begin
						next_locked = 1'b1;
						next_burn = TEST_DISABLE;
						next_mode = MPG_SYSTEM;
					end
				end
				default: begin
					if (EVENT.valid) begin
						case (EVENT.kind)
							MPG_EV_IRQ: begin
								next_mode = EVENT.user ? MPG_USER : MPG_SYSTEM;
								next_saved_mode = mode;
								next_jump.valid = 1'b1;
								next_jump.addr = vec_addr(MPG_VEC_IRQ_BASE, EVENT.index);
							end
							MPG_EV_CONFIG_VECTOR: begin
								if (ev_config_vector_ok) begin
									next_mode = MPG_CLOS;
									next_saved_mode = mode;
									next_jump.valid = 1'b1;
									next_jump.addr = vec_addr(MPG_VEC_CFG_BASE, EVENT.index);
								end
							end
							MPG_EV_SYSTEM_CALL_VECTOR: begin
								if (ev_system_call_vector_ok) begin
									next_mode = MPG_SYSTEM;
									next_saved_mode = mode;
									next_jump.valid = 1'b1;
									next_jump.addr = vec_addr(MPG_VEC_SYS_BASE, EVENT.index);
								end
							end
							MPG_EV_RET: begin
								// A single saved level; only a saved System or User mode is restored, and a nested outer return lands in System.
								if (saved_mode == MPG_SYSTEM || saved_mode == MPG_USER) begin
									next_mode = saved_mode;
								end else begin
									next_mode = MPG_SYSTEM;
								end
								next_saved_mode = MPG_SYSTEM;
							end
							default: begin
								next_mode = mode;
							end
						endcase
					end
				end
			endcase
		end
	end

	// Registers; reset always lands in Boot mode with a cleared lock copy.
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			mode <= MPG_BOOT;
			saved_mode <= MPG_SYSTEM;
			locked <= 1'b0;
			JUMP <= '0;
			FAULT <= 1'b0;
			FUSE_BURN <= 1'b0;
		end else begin
			mode <= next_mode;
			saved_mode <= next_saved_mode;
			locked <= next_locked;
			JUMP <= next_jump;
			FAULT <= next_fault;
			FUSE_BURN <= next_burn;
		end
	end

	// Super-system flag groups the three factory submodes.
	always_comb begin
		MODE = mode;
		SUPER = mode == MPG_BOOT || mode == MPG_TEST || mode == MPG_CLOS;
	end

	default clocking cb @(posedge CLK); endclocking
	default disable iff (SYS_RST);

	a_boot_after_reset: assert property ($past(SYS_RST) |-> mode == MPG_BOOT)
		else $error("mode is not Boot after reset");
	a_irq_mode_set: assert property (EVENT.valid && EVENT.kind == MPG_EV_IRQ && ev_customer && !violation
		|=> JUMP.valid && mode == ($past(EVENT.user) ? MPG_USER : MPG_SYSTEM))
		else $error("interrupt did not set handler mode");
	a_config_vector_enter: assert property (EVENT.valid && EVENT.kind == MPG_EV_CONFIG_VECTOR && ev_config_vector_ok && !violation
		|=> mode == MPG_CLOS && SUPER)
		else $error("config vector did not enter contactless OS");
	a_system_call_vector_enter: assert property (EVENT.valid && EVENT.kind == MPG_EV_SYSTEM_CALL_VECTOR && ev_system_call_vector_ok && !violation
		|=> mode == MPG_SYSTEM && JUMP.valid)
		else $error("system-call vector did not enter System mode");
	a_config_vector_suppress: assert property (mode == MPG_SYSTEM && !CFG.clos_enable && !violation |=> mode != MPG_CLOS)
		else $error("contactless OS entered while disabled");
	a_test_open: assert property (mode == MPG_TEST && CPU_ACC.valid && cpu_range |-> CPU_GRANT)
		else $error("test mode access refused");
	a_priv_only: assert property ((mode == MPG_BOOT || mode == MPG_CLOS) && CPU_GRANT && !sfr_acc |-> cpu_priv)
		else $error("factory mode reached customer partition");
	a_cust_only: assert property ((mode == MPG_SYSTEM || mode == MPG_USER) && CPU_GRANT && !sfr_acc |-> !cpu_priv)
		else $error("customer mode reached privileged partition");
	a_sys_sfr: assert property (mode == MPG_SYSTEM && CPU_ACC.valid && sfr_acc && cpu_range |-> CPU_GRANT)
		else $error("System mode refused a special register");
	a_user_mmu: assert property (mode == MPG_USER && CPU_ACC.valid && !MMU_OK && !(sfr_acc
		&& CPU_ACC.addr < MPG_SFR_USER_LIMIT) |-> !CPU_GRANT)
		else $error("User access granted without MMU right");
	a_cop_bound: assert property (COP_GRANT |-> !cop_priv && (COP_ACC.space == MPG_SP_EE || cop_own))
		else $error("coprocessor left its partition");
	a_test_lock: assert property (locked |-> ##1 mode != MPG_TEST [*2])
		else $error("test mode reachable after disable");
	a_startup_path: assert property (mode == MPG_BOOT && BOOT_DONE && !violation
		|=> mode == ($past(test_off) ? MPG_SYSTEM : MPG_TEST))
		else $error("start-up went to the wrong mode");
	a_fault_trap: assert property (violation && mode != MPG_TEST |-> !CPU_GRANT ##1 FAULT && mode == MPG_SYSTEM
		&& JUMP.addr == MPG_VEC_FAULT)
		else $error("violation was not trapped");

	c_config_vector_call: cover property (mode == MPG_SYSTEM ##1 mode == MPG_CLOS);
	c_test_entry: cover property (mode == MPG_BOOT ##1 mode == MPG_TEST);
	c_fault_trap: cover property (mode == MPG_USER && violation ##1 FAULT);
	c_fuse_burn: cover property (FUSE_BURN);
endmodule

// ### mpg_guard_tb_top.sv
// Self-checking testbench for the CPU mode and memory partition guard.
`timescale 1ns/100ps
module mpg_guard_tb_top;
	import mpg_pkg::*;
	logic clk, sys_rst, test_fuse_off, mmu_ok, boot_done, test_disable, cpu_grant, cop_grant, super_flag, fault, fuse_burn;
	mpg_config_type cfg;
	mpg_access_type cop_acc, cpu_acc;
	mpg_event_req_type ev_req;
	mpg_mode_type mode;
	mpg_jump_type jump;
	int n_errors = 0;
	int samples_checked = 0;
	mpg_guard mpg_guard_i (.CLK(clk), .SYS_RST(sys_rst), .CFG(cfg), .TEST_FUSE_OFF(test_fuse_off),
		.TEST_DISABLE(test_disable), .BOOT_DONE(boot_done), .EVENT(ev_req), .CPU_ACC(cpu_acc), .MMU_OK(mmu_ok),
		.COP_ACC(cop_acc), .CPU_GRANT(cpu_grant), .COP_GRANT(cop_grant), .MODE(mode), .SUPER(super_flag),
		.JUMP(jump), .FAULT(fault), .FUSE_BURN(fuse_burn));
	mpg_core_model mpg_core_model_i (.CLK(clk), .EVENT(ev_req), .CPU_ACC(cpu_acc), .MMU_OK(mmu_ok),
		.BOOT_DONE(boot_done), .TEST_DISABLE(test_disable));
	// Clock of 4 ns and the time-zero values of the bench-driven inputs.
	initial begin
		clk = 1'b0;
		sys_rst = 1'b1;
		test_fuse_off = 1'b0;
		cop_acc = '0;
		cfg = '{MPG_EE_RES_1K, 1'b1, 1'b1};
		forever #2 clk = ~clk;
	end
	// Shared comparison; counts every check and reports a mismatch at once.
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %s expected %0h seen %0h", name, exp, got);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// Reset for 8 cycles; the guard must come out in Boot mode.
	task automatic do_reset(input logic fuse);
		@(negedge clk);
		sys_rst = 1'b1;
		test_fuse_off = fuse;
		repeat (8) @(negedge clk);
		sys_rst = 1'b0;
		chk("MODE", MPG_BOOT, mode);
		chk("SUPER", 1, super_flag);
	endtask
	// One CPU access: grant is looked at mid-cycle, FAULT one cycle later.
	task automatic acc(input mpg_space_type sp, input logic [17:0] ad, input logic mmu, input logic exp);
		mpg_core_model_i.put_acc('{1'b1, sp, ad}, mmu);
		#1 chk("CPU_GRANT", exp, cpu_grant);
		mpg_core_model_i.put_acc('0, mmu);
		chk("FAULT", !exp, fault);
	endtask
	// One event; jc 1 expects a jump to ja, 0 expects none, 2 leaves the jump unchecked.
	task automatic ev(input mpg_event_type k, input int i, input logic u, input mpg_mode_type m,
		input logic [17:0] ja, input int jc);
		mpg_core_model_i.put_ev('{1'b1, k, i[4:0], u});
		chk("MODE", m, mode);
		if (jc == 1) chk("JUMP", {1'b1, ja}, jump);
		if (jc == 0) chk("JUMP.valid", 0, jump.valid);
	endtask
	// One coprocessor access; a refusal must never raise FAULT.
	task automatic cop(input mpg_space_type sp, input logic [17:0] ad, input logic exp);
		@(negedge clk);
		cop_acc = '{1'b1, sp, ad};
		#1 chk("COP_GRANT", exp, cop_grant);
		@(negedge clk);
		cop_acc = '{1'b0, sp, ~ad};
		chk("FAULT", 0, fault);
	endtask
	// Boot grants only; a refusal here would trap out of Boot before the test reaches it.
	task automatic t_boot();
		acc(MPG_SP_ROM, 18'h32000, 1'b0, 1'b1);
		acc(MPG_SP_EE, 18'h13b80, 1'b0, 1'b1);
		acc(MPG_SP_RAM, 18'h0007f, 1'b0, 1'b1);
		ev(MPG_EV_SYSTEM_CALL_VECTOR, 0, 1'b0, MPG_BOOT, 18'h0, 0);
		mpg_core_model_i.pulse(1'b0);
		chk("MODE", MPG_TEST, mode);
	endtask
	task automatic t_test();
		acc(MPG_SP_ROM, 18'h00000, 1'b0, 1'b1);
		acc(MPG_SP_RAM, 18'h017ff, 1'b0, 1'b1);
		acc(MPG_SP_ROM, 18'h38000, 1'b0, 1'b0);
		chk("MODE", MPG_TEST, mode);
		mpg_core_model_i.pulse(1'b1);
		chk("FUSE_BURN", 1, fuse_burn);
		chk("MODE", MPG_SYSTEM, mode);
	endtask
	task automatic t_system();
		acc(MPG_SP_ROM, 18'h31fff, 1'b0, 1'b1);
		acc(MPG_SP_SFR, 18'h0007f, 1'b0, 1'b1);
		acc(MPG_SP_EE, 18'h13b7f, 1'b0, 1'b1);
		acc(MPG_SP_RAM, 18'h00080, 1'b0, 1'b1);
		acc(MPG_SP_ROM, 18'h32000, 1'b0, 1'b0);
		chk("JUMP", {1'b1, MPG_VEC_FAULT}, jump);
		chk("SUPER", 0, super_flag);
		acc(MPG_SP_RAM, 18'h0007f, 1'b0, 1'b0);
		cfg.ram_res = 1'b0;
		acc(MPG_SP_RAM, 18'h00000, 1'b0, 1'b1);
		cfg.ee_res = MPG_EE_RES_0K;
		acc(MPG_SP_EE, 18'h13f7f, 1'b0, 1'b1);
		acc(MPG_SP_EE, 18'h13f80, 1'b0, 1'b0);
		cfg.ee_res = MPG_EE_RES_4K;
		acc(MPG_SP_EE, 18'h12f7f, 1'b0, 1'b1);
		acc(MPG_SP_EE, 18'h12f80, 1'b0, 1'b0);
	endtask
	// Every config index and one past, the contactless OS limits, then every system-call index.
	task automatic t_vectors();
		for (int i = 0; i < 9; i++) begin
			ev(MPG_EV_CONFIG_VECTOR, i, 1'b0, (i < 8) ? MPG_CLOS : MPG_SYSTEM, MPG_VEC_CFG_BASE + 18'(i * 8), (i < 8) ? 1 : 0);
			if (i < 8) ev(MPG_EV_RET, 0, 1'b0, MPG_SYSTEM, 18'h0, 2);
		end
		ev(MPG_EV_CONFIG_VECTOR, 1, 1'b0, MPG_CLOS, MPG_VEC_CFG_BASE + 18'h8, 1);
		acc(MPG_SP_EE, 18'h12f80, 1'b0, 1'b1);
		acc(MPG_SP_ROM, 18'h00100, 1'b0, 1'b0);
		chk("MODE", MPG_SYSTEM, mode);
		cfg.clos_enable = 1'b0;
		ev(MPG_EV_CONFIG_VECTOR, 0, 1'b0, MPG_SYSTEM, 18'h0, 0);
		ev(MPG_EV_IRQ, 3, 1'b1, MPG_USER, MPG_VEC_IRQ_BASE + 18'h18, 1);
		for (int i = 0; i < 32; i++) begin
			ev(MPG_EV_SYSTEM_CALL_VECTOR, i, 1'b0, MPG_SYSTEM, MPG_VEC_SYS_BASE + 18'(i * 8), 1);
			ev(MPG_EV_RET, 0, 1'b0, MPG_USER, 18'h0, 2);
		end
	endtask
	task automatic t_user();
		acc(MPG_SP_SFR, 18'h0000f, 1'b0, 1'b1);
		acc(MPG_SP_SFR, 18'h00010, 1'b1, 1'b1);
		acc(MPG_SP_ROM, 18'h00100, 1'b1, 1'b1);
		acc(MPG_SP_SFR, 18'h00010, 1'b0, 1'b0);
		chk("MODE", MPG_SYSTEM, mode);
	endtask
	task automatic t_cop();
		cop(MPG_SP_RAM, 18'h00dff, 1'b0);
		cop(MPG_SP_RAM, 18'h00e00, 1'b1);
		cop(MPG_SP_RAM, 18'h017ff, 1'b1);
		cop(MPG_SP_RAM, 18'h01800, 1'b0);
		cop(MPG_SP_ROM, 18'h00100, 1'b0);
		cop(MPG_SP_EE, 18'h12f7f, 1'b1);
		cop(MPG_SP_EE, 18'h12f80, 1'b0);
	endtask
	// Main sequence.
	initial begin
		do_reset(1'b0);
		t_boot();
		t_test();
		t_system();
		t_vectors();
		t_user();
		t_cop();
		do_reset(1'b1);
		mpg_core_model_i.pulse(1'b0);
		chk("MODE", MPG_SYSTEM, mode);
		report_and_stop();
	end
	// A hang is cut short at 200000 ns, far above the normal run time, and counted as a mismatch.
	initial begin
		#200000;
		n_errors++;
		report_and_stop();
	end
endmodule

// ### mpg_part_check.sv
// Address classifier that tells range, privileged part and coprocessor RAM.
`timescale 1ns/100ps
module mpg_part_check (
	input wire mpg_pkg::mpg_access_type acc, // Access to classify.
	input wire mpg_pkg::mpg_config_type cfg, // Partition configuration.
	output logic in_range, // Address lies inside the memory.
	output logic priv, // Address lies in the privileged part.
	output logic cop_ram // Address lies in coprocessor RAM.
);
	import mpg_pkg::*;

	logic [MPG_ADDR_W-1:0] ee_priv_base;
	logic [MPG_ADDR_W-1:0] ram_priv_top;

	// Privileged EEPROM sits at the top and privileged RAM at the bottom.
	always_comb begin
		case (cfg.ee_res)
			MPG_EE_RES_1K: ee_priv_base = MPG_ADDR_W'(MPG_EE_BYTES - MPG_EE_MFR_BYTES - 1024);
			MPG_EE_RES_4K: ee_priv_base = MPG_ADDR_W'(MPG_EE_BYTES - MPG_EE_MFR_BYTES - 4096);
			default: ee_priv_base = MPG_ADDR_W'(MPG_EE_BYTES - MPG_EE_MFR_BYTES);
		endcase
		ram_priv_top = cfg.ram_res ? MPG_ADDR_W'(MPG_RAM_PRIV_BYTES) : '0;
	end

	// Classification per memory space.
	always_comb begin
		in_range = 1'b0;
		priv = 1'b0;
		cop_ram = 1'b0;
		case (acc.space)
			MPG_SP_ROM: begin
				in_range = acc.addr < MPG_ADDR_W'(MPG_ROM_BYTES);
				priv = acc.addr >= MPG_ADDR_W'(MPG_ROM_APP_BYTES);
			end
			MPG_SP_EE: begin
				in_range = acc.addr < MPG_ADDR_W'(MPG_EE_BYTES);
				priv = acc.addr >= ee_priv_base;
			end
			MPG_SP_RAM: begin
				in_range = acc.addr < MPG_ADDR_W'(MPG_RAM_BYTES);
				priv = acc.addr < ram_priv_top;
				cop_ram = acc.addr >= MPG_ADDR_W'(MPG_RAM_GP_BYTES);
			end
			MPG_SP_SFR: begin
				in_range = acc.addr < MPG_SFR_TOP;
			end
			default: begin
				in_range = 1'b0;
			end
		endcase
	end
endmodule

// ### mpg_pkg.sv
// Package of constants and types for the CPU mode and memory partition guard.
package mpg_pkg;

	// Memory geometry in bytes.
	localparam int unsigned MPG_ROM_BYTES = 224 * 1024;
	localparam int unsigned MPG_ROM_APP_BYTES = 200 * 1024;
	localparam int unsigned MPG_ROM_FACT_BYTES = 24 * 1024;
	localparam int unsigned MPG_EE_BYTES = 80 * 1024;
	localparam int unsigned MPG_EE_MFR_BYTES = 128;
	localparam int unsigned MPG_RAM_BYTES = 6144;
	localparam int unsigned MPG_RAM_PRIV_BYTES = 128;
	localparam int unsigned MPG_RAM_GP_BYTES = 3584;
	localparam int unsigned MPG_RAM_COP_BYTES = 2560;

	// Address width that covers the largest memory.
	localparam int unsigned MPG_ADDR_W = 18;

	// Special function registers below this address stay open to User mode.
	localparam logic [MPG_ADDR_W-1:0] MPG_SFR_USER_LIMIT = 18'h00010;
	localparam logic [MPG_ADDR_W-1:0] MPG_SFR_TOP = 18'h00080;

	// Fixed vector addresses in the factory ROM region and their spacing.
	localparam logic [MPG_ADDR_W-1:0] MPG_VEC_IRQ_BASE = 18'h32000;
	localparam logic [MPG_ADDR_W-1:0] MPG_VEC_CFG_BASE = 18'h32400;
	localparam logic [MPG_ADDR_W-1:0] MPG_VEC_SYS_BASE = 18'h32800;
	localparam logic [MPG_ADDR_W-1:0] MPG_VEC_FAULT = 18'h32c00;
	localparam int unsigned MPG_VEC_SHIFT = 3;

	// Counts of vectors and the width of a vector index.
	localparam int unsigned MPG_NUM_CONFIG_VECTOR = 8;
	localparam int unsigned MPG_NUM_SYSTEM_CALL_VECTOR = 32;
	localparam int unsigned MPG_VIDX_W = 5;

	// CPU modes, Gray coded along boot, test, system, user, then contactless OS.
	typedef enum logic [2:0] {
		MPG_BOOT = 3'h0,
		MPG_TEST = 3'h1,
		MPG_SYSTEM = 3'h3,
		MPG_USER = 3'h2,
		MPG_CLOS = 3'h6
	} mpg_mode_type;

	// Memory spaces that an access can target.
	typedef enum logic [1:0] {
		MPG_SP_ROM = 2'h0,
		MPG_SP_EE = 2'h1,
		MPG_SP_RAM = 2'h2,
		MPG_SP_SFR = 2'h3
	} mpg_space_type;

	// Mode-changing requests from the core.
	typedef enum logic [1:0] {
		MPG_EV_IRQ = 2'h0,
		MPG_EV_CONFIG_VECTOR = 2'h1,
		MPG_EV_SYSTEM_CALL_VECTOR = 2'h2,
		MPG_EV_RET = 2'h3
	} mpg_event_type;

	// Reserved EEPROM size codes for the contactless OS.
	localparam logic [1:0] MPG_EE_RES_0K = 2'h0;
	localparam logic [1:0] MPG_EE_RES_1K = 2'h1;
	localparam logic [1:0] MPG_EE_RES_4K = 2'h2;

	// One memory access.
	typedef struct packed {
		logic valid;
		mpg_space_type space;
		logic [MPG_ADDR_W-1:0] addr;
	} mpg_access_type;

	// One event request; user selects the handler mode of an interrupt.
	typedef struct packed {
		logic valid;
		mpg_event_type kind;
		logic [MPG_VIDX_W-1:0] index;
		logic user;
	} mpg_event_req_type;

	// Partition configuration.
	typedef struct packed {
		logic [1:0] ee_res;
		logic ram_res;
		logic clos_enable;
	} mpg_config_type;

	// Vector jump towards the core.
	typedef struct packed {
		logic valid;
		logic [MPG_ADDR_W-1:0] addr;
	} mpg_jump_type;

endpackage
